// File: rtl/ppom_defines.svh
// Purpose: Offsets, field positions, reset values for the port pin override mux.
// Assumes: AHB-Lite word registers, decode on haddr[11:0].
// Notes: Included by the design file and the bench.
`ifndef PPOM_DEFINES_SVH
`define PPOM_DEFINES_SVH
`define PPOM_OFF_DIR 12'h000
`define PPOM_OFF_LATCH 12'h004
`define PPOM_OFF_PIN 12'h008
`define PPOM_OFF_SFIO 12'h00c
`define PPOM_OFF_XCTRL 12'h010
`define PPOM_OFF_CHGEN 12'h014
`define PPOM_PUD_BIT 2
`define PPOM_XME_BIT 0
`define PPOM_GRP_BIT 1
`define PPOM_RST_BYTE 8'h00
`endif

// File: rtl/ppom_pkg.sv
// Purpose: Types for the port pin override mux.
// Assumes: Eight pins on the first port.
// Notes: Offsets live in ppom_defines.svh.
package ppom_pkg;
	typedef struct packed {
		logic address_phase_active;
		logic write_strobe;
		logic [7:0] addr;
		logic [7:0] data_out;
	} ppom_xmem_t;
	typedef struct packed {
		logic [7:0] pad_out;
		logic [7:0] pad_oe_n;
		logic [7:0] pullup_en;
	} ppom_pad_t;
	typedef struct packed {
		logic [7:0] direction_bit;
		logic [7:0] output_latch_bit;
		logic [7:0] sfio;
		logic [1:0] xctrl;
		logic [7:0] chg_en;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic ap_valid;
		logic ap_write;
		logic [11:0] ap_addr;
	} ppom_state_t;
endpackage

// File: rtl/ppom_port_mux.sv
// Purpose: First-port pin override mux with AHB-Lite register access.
// Assumes: Memory interface signals arrive on hclk; pad_in is asynchronous.
// Notes: Input taps are unsynchronised by design; pin readback is synchronised.
`include "ppom_defines.svh"
module ppom_port_mux #(
	parameter int PIN_COUNT = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire ppom_pkg::ppom_xmem_t xmem,
	input wire logic deep_sleep,
	input wire logic [7:0] pad_in,
	output ppom_pkg::ppom_pad_t pad,
	output logic [7:0] alt_function_input_tap,
	output logic [7:0] ext_data_in,
	output logic [7:0] change_irq_line_n,
	output logic ext_mem_enable,
	output logic change_irq_group_enable
);
	import ppom_pkg::*;

	ppom_state_t s_q;
	ppom_state_t s_d;
	logic xme;
	logic grp;
	logic global_pullup_off;
	logic wa;
	logic [7:0] pull_up_override_enable;
	logic [7:0] pull_up_override_value;
	logic [7:0] direction_override_enable;
	logic [7:0] direction_override_value;
	logic [7:0] pin_value_override_enable;
	logic [7:0] pin_value_override_value;
	logic [7:0] input_enable_override_enable;
	logic [7:0] input_enable_override_value;
	logic [7:0] drv_en;
	logic [7:0] pin_val;
	logic [7:0] pull;
	logic [7:0] in_en;
	logic [7:0] tap;
	logic ap_take;

	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	// The pin registers and the pad struct are one byte wide, so only eight pins are served.
	if (PIN_COUNT != 8) begin
		$error("ppom_port_mux serves exactly eight pins");
	end

	// ------------------------------------------------------------
	// Override signals of the memory interface and change interrupts
	// ------------------------------------------------------------
	assign xme = s_q.xctrl[`PPOM_XME_BIT];
	assign grp = s_q.xctrl[`PPOM_GRP_BIT];
	assign global_pullup_off = s_q.sfio[`PPOM_PUD_BIT];
	assign wa = xmem.write_strobe | xmem.address_phase_active;
	assign pull_up_override_enable = {8{xme}};
	assign pull_up_override_value = {8{~wa}} & s_q.output_latch_bit;
	assign direction_override_enable = {8{xme}};
	assign direction_override_value = {8{wa}};
	assign pin_value_override_enable = {8{xme}};
	assign pin_value_override_value = xmem.address_phase_active ? xmem.addr :
		(xmem.data_out & {8{xmem.write_strobe}});
	assign input_enable_override_enable = {8{grp}} & s_q.chg_en;
	assign input_enable_override_value = 8'hff;

	// ------------------------------------------------------------
	// Per-pin control
	// ------------------------------------------------------------
	// Overrides win pin by pin; without them the pin behaves as plain general-purpose I/O.
	assign pull = (pull_up_override_enable & pull_up_override_value)
		| (~pull_up_override_enable & ~s_q.direction_bit & s_q.output_latch_bit
		& ~{8{global_pullup_off}});
	assign drv_en = (direction_override_enable & direction_override_value)
		| (~direction_override_enable & s_q.direction_bit);
	assign pin_val = (pin_value_override_enable & pin_value_override_value)
		| (~pin_value_override_enable & s_q.output_latch_bit);
	assign in_en = (input_enable_override_enable & input_enable_override_value)
		| (~input_enable_override_enable & {8{~deep_sleep}});
	// The clamp grounds the input ahead of the Schmitt trigger.
	// The taps leave unsynchronised; every receiver brings its own synchroniser.
	assign tap = pad_in & in_en;

	// A pin whose driver is off shows a low output value, so the pad never sees stale data.
	assign pad = '{
		pad_out: pin_val & drv_en,
		pad_oe_n: ~drv_en,
		pullup_en: pull
	};
	assign alt_function_input_tap = tap;
	assign ext_data_in = tap;
	assign change_irq_line_n = tap;
	assign ext_mem_enable = xme;
	assign change_irq_group_enable = grp;

	// ------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// Only whole-word transfers are taken; other sizes pass with no effect.
	assign ap_take = hsel & hready & htrans[1] & (hsize == 3'h2);

	// Read data stands only in the data phase and is zero for unmapped offsets.
	always_comb begin
		hrdata = 32'h00000000;
		if (s_q.ap_valid && !s_q.ap_write) begin
			if (s_q.ap_addr == `PPOM_OFF_DIR) begin
				hrdata = {24'h000000, s_q.direction_bit};
			end else if (s_q.ap_addr == `PPOM_OFF_LATCH) begin
				hrdata = {24'h000000, s_q.output_latch_bit};
			end else if (s_q.ap_addr == `PPOM_OFF_PIN) begin
				hrdata = {24'h000000, s_q.sync2};
			end else if (s_q.ap_addr == `PPOM_OFF_SFIO) begin
				hrdata = {24'h000000, s_q.sfio};
			end else if (s_q.ap_addr == `PPOM_OFF_XCTRL) begin
				hrdata = {30'h0, s_q.xctrl};
			end else if (s_q.ap_addr == `PPOM_OFF_CHGEN) begin
				hrdata = {24'h000000, s_q.chg_en};
			end
		end
	end

	// ------------------------------------------------------------
	// State update
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.sync1 = tap;
		s_d.sync2 = s_q.sync1;
		// The address phase is held for the data phase that follows it.
		if (hready) begin
			s_d.ap_valid = ap_take;
			s_d.ap_write = hwrite;
			s_d.ap_addr = haddr[11:0];
		end
		if (s_q.ap_valid && s_q.ap_write) begin
			if (s_q.ap_addr == `PPOM_OFF_DIR) begin
				s_d.direction_bit = hwdata[7:0];
			end else if (s_q.ap_addr == `PPOM_OFF_LATCH) begin
				s_d.output_latch_bit = hwdata[7:0];
			end else if (s_q.ap_addr == `PPOM_OFF_SFIO) begin
				s_d.sfio = hwdata[7:0];
			end else if (s_q.ap_addr == `PPOM_OFF_XCTRL) begin
				s_d.xctrl = hwdata[1:0];
			end else if (s_q.ap_addr == `PPOM_OFF_CHGEN) begin
				s_d.chg_en = hwdata[7:0];
			end
		end
	end

	// Reset clears every override enable, so the pins come up as tri-stated inputs.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Each register write lands at the edge that ends its data phase, so the
	// write sequences end one cycle after the address phase is taken.
	sequence dir_write_s;
		(ap_take && hwrite && haddr[11:0] == `PPOM_OFF_DIR) ##1 1'b1;
	endsequence
	sequence latch_write_s;
		(ap_take && hwrite && haddr[11:0] == `PPOM_OFF_LATCH) ##1 1'b1;
	endsequence
	sequence sfio_write_s;
		(ap_take && hwrite && haddr[11:0] == `PPOM_OFF_SFIO) ##1 1'b1;
	endsequence
	sequence xctrl_write_s;
		(ap_take && hwrite && haddr[11:0] == `PPOM_OFF_XCTRL) ##1 1'b1;
	endsequence
	sequence chgen_write_s;
		(ap_take && hwrite && haddr[11:0] == `PPOM_OFF_CHGEN) ##1 1'b1;
	endsequence
	// A write of any size but a word is seen on the bus and must change nothing.
	sequence narrow_write_s;
		(hsel && hready && htrans[1] && hwrite && hsize != 3'h2) ##1 1'b1;
	endsequence
	sequence dir_read_s;
		(ap_take && !hwrite && haddr[11:0] == `PPOM_OFF_DIR) ##1 1'b1;
	endsequence
	sequence pin_read_s;
		(ap_take && !hwrite && haddr[11:0] == `PPOM_OFF_PIN) ##1 1'b1;
	endsequence
	// Memory interface owns the pins and neither drives them nor strobes a write.
	sequence xm_idle_s;
		ext_mem_enable && !xmem.write_strobe && !xmem.address_phase_active;
	endsequence
	sequence xm_drive_s;
		ext_mem_enable && (xmem.write_strobe || xmem.address_phase_active);
	endsequence
	sequence xm_write_s;
		ext_mem_enable && xmem.write_strobe && !xmem.address_phase_active;
	endsequence

	// ------------------------------------------------------------
	// Pull-up checks
	// ------------------------------------------------------------
	pu_override_a: assert property (xme |->
		pad.pullup_en == ({8{~wa}} & s_q.output_latch_bit))
		else $error("pull-up does not follow memory override");
	pu_plain_a: assert property (!xme |->
		pad.pullup_en == (~s_q.direction_bit & s_q.output_latch_bit & ~{8{global_pullup_off}}))
		else $error("plain pull-up wrong");
	xm_pull_idle_a: assert property (xm_idle_s |->
		pad.pullup_en == s_q.output_latch_bit)
		else $error("released memory pins lost the latch pull-up");
	xm_pull_drive_a: assert property (xm_drive_s |->
		pad.pullup_en == 8'h00)
		else $error("pull-up left on while memory drives the pins");
	pud_plain_a: assert property ((!ext_mem_enable && global_pullup_off) |->
		pad.pullup_en == 8'h00)
		else $error("pull-up on while globally disabled");
	pu_disable_a: assert property (sfio_write_s |=>
		global_pullup_off == $past(hwdata[`PPOM_PUD_BIT]) && (xme || !global_pullup_off || pad.pullup_en == 8'h00))
		else $error("pull-up disable ignored");

	// ------------------------------------------------------------
	// Direction and value checks
	// ------------------------------------------------------------
	dir_override_a: assert property (xme |->
		pad.pad_oe_n == {8{~wa}})
		else $error("driver enable not from memory interface");
	plain_dir_a: assert property (!ext_mem_enable |->
		pad.pad_oe_n == ~s_q.direction_bit)
		else $error("driver enable not from direction bits");
	dir_write_a: assert property (dir_write_s |=>
		s_q.direction_bit == $past(hwdata[7:0])
		&& (xme || pad.pad_oe_n == ~$past(hwdata[7:0])))
		else $error("direction write not applied");
	xm_release_a: assert property (xm_idle_s |->
		pad.pad_oe_n == 8'hff && pad.pad_out == 8'h00)
		else $error("memory pins driven outside address phase and write");
	xm_drive_a: assert property (xm_drive_s |->
		pad.pad_oe_n == 8'h00)
		else $error("memory pins not driven during address phase or write");
	addr_out_a: assert property ((xme && xmem.address_phase_active) |->
		pad.pad_out == xmem.addr)
		else $error("address not driven");
	xm_data_a: assert property (xm_write_s |->
		pad.pad_out == xmem.data_out)
		else $error("write data not driven over the latch");
	value_plain_a: assert property (!xme |->
		pad.pad_out == (s_q.output_latch_bit & s_q.direction_bit))
		else $error("latch value not driven");
	latch_write_a: assert property (latch_write_s |=>
		s_q.output_latch_bit == $past(hwdata[7:0]))
		else $error("latch write not applied");
	xctrl_write_a: assert property (xctrl_write_s |=>
		ext_mem_enable == $past(hwdata[`PPOM_XME_BIT])
		&& change_irq_group_enable == $past(hwdata[`PPOM_GRP_BIT]))
		else $error("memory or group enable write not applied");
	narrow_write_a: assert property (narrow_write_s |=>
		s_q.direction_bit == $past(s_q.direction_bit) && s_q.sfio == $past(s_q.sfio))
		else $error("sub-word write changed a register");

	// ------------------------------------------------------------
	// Input enable and tap checks
	// ------------------------------------------------------------
	awake_input_a: assert property (!deep_sleep |->
		alt_function_input_tap == pad_in)
		else $error("awake input not passed to the tap");
	input_keep_a: assert property ((grp && deep_sleep) |->
		(tap & s_q.chg_en) == (pad_in & s_q.chg_en))
		else $error("enabled change input clamped in sleep");
	sleep_clamp_a: assert property ((deep_sleep && change_irq_group_enable) |->
		(alt_function_input_tap & ~s_q.chg_en) == 8'h00)
		else $error("disabled change input not clamped in sleep");
	clamp_a: assert property ((deep_sleep && !grp) |->
		tap == 8'h00)
		else $error("input not clamped in deep sleep");
	chgen_write_a: assert property (chgen_write_s |=>
		s_q.chg_en == $past(hwdata[7:0]))
		else $error("change line enable write not applied");
	// Readback lags the tap by the two synchroniser flops.
	pin_sync_a: assert property (1'b1 ##2 1'b1 |->
		s_q.sync2 == $past(tap, 2))
		else $error("pin readback not two flops behind tap");
	dir_read_a: assert property (dir_read_s |->
		hrdata == {24'h000000, s_q.direction_bit})
		else $error("direction readback wrong");
	pin_read_a: assert property (pin_read_s |->
		hrdata == {24'h000000, s_q.sync2})
		else $error("pin readback wrong");
endmodule

// File: verification/ppom_xmem_model.sv
// Purpose: Memory interface model that drives the pin overrides.
// Assumes: Requests are levels sampled on hclk.
// Notes: Released address and data lines invert their held value every cycle, so they toggle.
module ppom_xmem_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ada,
	input wire logic wr,
	input wire logic [7:0] a,
	input wire logic [7:0] d,
	output ppom_pkg::ppom_xmem_t xmem
);
	timeunit 1ns;
	timeprecision 1ns;
	import ppom_pkg::*;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xmem <= '0;
		end else begin
			xmem.address_phase_active <= ada;
			xmem.write_strobe <= wr;
			xmem.addr <= ada ? a : ~xmem.addr;
			xmem.data_out <= wr ? d : ~xmem.data_out;
		end
	end
endmodule

// File: verification/test_port_pin_override_mux.sv
// Purpose: Self-checking bench for the port pin override mux.
// Assumes: Zero wait state slave, combinational pin mux.
// Notes: Expected values queue up and are compared as they appear.
`include "ppom_defines.svh"
module test_port_pin_override_mux;
	timeunit 1ns;
	timeprecision 1ns;
	import ppom_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
	logic chk = 0, sel = 0, ada = 0, wr = 0, slp = 0, xme = 0, grp = 0, global_pullup_off = 0, xo, go;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [7:0] a = 0, d = 0, pin = 0, dir = 0, lat = 0, chg = 0, sf = 0, tap, edi, cil;
	logic [33:0] ex, obs, pe;
	logic [33:0] exq[$];
	ppom_xmem_t xmem;
	ppom_pad_t pad;
	int err_total = 0, n_tests = 0, cyc = 0;
	assign hready = hreadyout;
	always #10 hclk = ~hclk;
	ppom_xmem_model partner (.hclk(hclk), .hresetn(hresetn), .ada(ada), .wr(wr), .a(a),
		.d(d), .xmem(xmem));
	ppom_port_mux dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .xmem(xmem),
		.deep_sleep(slp), .pad_in(pin), .pad(pad), .alt_function_input_tap(tap),
		.ext_data_in(edi), .change_irq_line_n(cil), .ext_mem_enable(xo),
		.change_irq_group_enable(go));
	// ----------------------------------------
	// Reference and checking
	// ----------------------------------------
	function automatic logic [33:0] exp_pad();
		logic [7:0] oe, val, pu, ie;
		oe = xme ? {8{wr | ada}} : dir;
		val = xme ? (ada ? a : d & {8{wr}}) : lat;
		pu = xme ? lat & {8{~(wr | ada)}} : ~dir & lat & {8{~global_pullup_off}};
		ie = (chg & {8{grp}}) | {8{~slp}};
		return {xme, grp, val & oe, ~oe, pu, pin & ie};
	endfunction
	always @(posedge hclk) begin
		if (chk) begin
			obs = sel ? {hresp, ~hreadyout, hrdata} : {xo, go, pad, tap};
			ex = exq.pop_front();
			n_tests++;
			if (obs !== ex) begin
				err_total++;
				$display("unexpected at %0t: got %h want %h", $time, obs, ex);
			end
			if (edi !== tap || cil !== tap) begin
				err_total++;
				$display("unexpected at %0t: input taps differ", $time);
			end
		end
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("Compares %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	task automatic bus(input logic [11:0] ad, input logic w, input logic [31:0] wd,
		input logic [31:0] e);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= {20'h0, ad};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		if (!w) begin
			exq.push_back({2'h0, e});
			sel <= 1;
			chk <= 1;
		end
		do @(posedge hclk); while (hreadyout !== 1'b1);
		chk <= 0;
	endtask
	task automatic pchk();
		exq.push_back(exp_pad());
		sel <= 0;
		chk <= 1;
		@(posedge hclk);
		chk <= 0;
	endtask
	initial begin
		r = $urandom(45240);
		repeat (3) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		pchk();
		$display("test reset_idle done");
		repeat (40) begin
			r = $urandom;
			{sf, chg, lat, dir} = r;
			global_pullup_off = sf[2];
			r = $urandom;
			{xme, grp} = r[1:0];
			bus(`PPOM_OFF_DIR, 1, {24'hffffff, dir}, 0);
			bus(`PPOM_OFF_LATCH, 1, {24'hffffff, lat}, 0);
			bus(`PPOM_OFF_SFIO, 1, {24'hffffff, sf}, 0);
			bus(`PPOM_OFF_XCTRL, 1, {30'h3fffffff, grp, xme}, 0);
			bus(`PPOM_OFF_CHGEN, 1, {24'hffffff, chg}, 0);
			r = $urandom;
			{slp, wr, ada, d, a, pin} <= r[26:0];
			@(posedge hclk);
			pchk();
			bus(`PPOM_OFF_DIR, 0, 0, {24'h0, dir});
			bus(`PPOM_OFF_LATCH, 0, 0, {24'h0, lat});
			bus(`PPOM_OFF_SFIO, 0, 0, {24'h0, sf});
			bus(`PPOM_OFF_XCTRL, 0, 0, {30'h0, grp, xme});
			bus(`PPOM_OFF_CHGEN, 0, 0, {24'h0, chg});
			pe = exp_pad();
			bus(`PPOM_OFF_PIN, 0, 0, {24'h0, pe[7:0]});
			bus(12'h020, 0, 0, 0);
		end
		$display("test random_mux done");
		hsize <= 3'h1;
		bus(`PPOM_OFF_DIR, 1, {24'h0, ~dir}, 0);
		hsize <= 3'h2;
		bus(`PPOM_OFF_DIR, 0, 0, {24'h0, dir});
		$display("test narrow_write done");
		complete_run();
	end
endmodule
